/* hw/mcc_pkg.sv */
// Shared constants and carrier types for the memory-map and cache control registers.
// Assumes an 8-bit I/O port bus from the system processor and a 32-bit memory address.
package mcc_pkg;

	// I/O ports and register indexes.
	localparam logic [15:0] MCC_IDX_PORT = 16'h00e0;
	localparam logic [15:0] MCC_DATA_PORT = 16'h00e4;
	localparam logic [7:0] MCC_IDX_SPLIT = 8'ha0;
	localparam logic [7:0] MCC_IDX_ENC = 8'ha1;
	localparam logic [7:0] MCC_IDX_CTL = 8'ha2;
	localparam logic [7:0] MCC_IDX_WIN0 = 8'ha3;

	// Encoding register fields.
	localparam int ENC_ISOLATE = 7;
	localparam int ENC_ROM_DECODE = 5;
	localparam int ENC_LOCK_OFF = 4;
	localparam int ENC_SPLIT_OFF = 3;
	localparam int ENC_LOW512 = 2;
	localparam int ENC_ROM_EN = 1;
	localparam int ENC_PARITY_OFF = 0;
	localparam logic [7:0] ENC_RW_MASK = 8'hbf;

	// Cache and timer register fields.
	localparam int CTL_TIMERS_OFF = 7;
	localparam int CTL_WIN1_OFF = 2;
	localparam int CTL_WIN0_OFF = 1;
	localparam int CTL_CACHE_OFF = 0;
	localparam logic [7:0] CTL_RW_MASK = 8'h87;

	// Low window fields.
	localparam int WIN_HI_MSB = 7;
	localparam int WIN_HI_LSB = 4;
	localparam int WIN_LO_MSB = 3;
	localparam int WIN_LO_LSB = 0;

	// Reset values.
	localparam logic [7:0] IDX_RESET = 8'h00;
	localparam logic [7:0] SPLIT_RESET = 8'h01;
	localparam logic [7:0] ENC_RESET = 8'hab;
	localparam logic [7:0] CTL_RESET = 8'h87;
	localparam logic [7:0] WIN0_RESET = 8'h00;

	// Address map.
	localparam logic [31:0] ADDR_LOW512_END = 32'h0007ffff;
	localparam logic [31:0] ADDR_LOW640_END = 32'h0009ffff;
	localparam logic [31:0] ADDR_HOLE_LO = 32'h000a0000;
	localparam logic [31:0] ADDR_HOLE_HI = 32'h000dffff;
	localparam logic [31:0] ADDR_ROM_LO = 32'h000e0000;
	localparam logic [31:0] ADDR_ROM_LO4K_HI = 32'h000e0fff;
	localparam logic [31:0] ADDR_ROM_HI = 32'h000fffff;
	localparam logic [31:0] ADDR_HIROM_LO = 32'hfffe0000;
	localparam logic [19:0] SPLIT_SIZE_256K = 20'h40000;
	localparam logic [19:0] SPLIT_SIZE_384K = 20'h60000;

	typedef enum logic [1:0] {
		MCC_LK_IDLE = 2'b00,
		MCC_LK_OWN = 2'b01,
		MCC_LK_WAIT = 2'b10
	} mcc_lock_e;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mcc_io_s;

	typedef struct packed {
		logic valid;
		logic wr;
		logic [31:0] addr;
	} mcc_mem_s;

	typedef struct packed {
		logic valid;
		logic ram;
		logic rom;
		logic wr_blocked;
		logic no_mem;
		logic split_hit;
		logic cacheable;
	} mcc_dec_s;

	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] split;
		logic [7:0] enc;
		logic [7:0] ctl;
		logic [7:0] win0;
		logic parity_pend;
		logic [7:0] rdata;
		logic chan_ack;
		mcc_dec_s dec;
		mcc_lock_e lock;
	} mcc_state_s;

endpackage

/* hw/mcc_regs.sv */
// Memory-map and cache control registers with the address decode they steer.
// Assumes one clock, inputs synchronous to it, and index/data port access by the processor.
// How it works
// RQ1: Isolation bit set blocks all channel requests.
// RQ2: Decode off leaves E0000-E0FFF to channel.
// RQ3: Locked processor cycle blocks all other grants.
// RQ4: Locked attempt waits while master owns channel.
// RQ5: Split bit zero enables split block.
// RQ6: 640KB low memory, 256KB split block.
// RQ7: 512KB low memory, 384KB split, gap unmapped.
// RQ8: Split point up to 896KB never cached.
// RQ9: ROM on: read ROM, write RAM.
// RQ10: Software should keep ROM disabled.
// RQ11: Parity bit zero checks; one clears pending.
// RQ12: Software also clears parity at port 0061.
// RQ13: Timer bit zero enables bus share timers.
// RQ14: Upper window check enabled at zero.
// RQ15: Lower window check enabled at zero.
// RQ16: Cache bit zero enables both caches.
// RQ17: Software flushes caches around enable changes.
// RQ18: A0000-DFFFF uncached; E0000-FFFFF follows ROM.
// RQ19: 512KB split makes 80000-DFFFF uncached.
// RQ20: Lower check off: 1MB-16MB all cacheable.
// RQ21: Window match is inclusive at both ends.
// RQ22: Low window nibbles against A23-A20, upper zero.
// RQ23: Index at 00E0, data at 00E4.
// RQ24: Split register gives A27-A20 of block.
`timescale 1ns/1ps

module mcc_regs
	import mcc_pkg::*;
(
	input wire logic ref_clk, // 200 MHz clock
	input wire logic rstn, // asynchronous reset, active low
	input wire logic ce, // clock enable, freezes all state while low
	input wire mcc_io_s io, // processor I/O request
	output logic io_hit, // I/O request addresses one of our ports
	output logic [7:0] io_rdata, // read data, valid the cycle after io.rd
	input wire mcc_mem_s mem, // memory address to classify
	output mcc_dec_s dec, // classification, one cycle after mem
	input wire logic [7:0] win1_lo, // upper window lower limit, A27-A20
	input wire logic [7:0] win1_hi, // upper window upper limit, A27-A20
	input wire logic chan_req, // channel request for system-board memory
	output logic chan_ack, // channel request accepted
	input wire logic cpu_lock, // processor lock signal active
	input wire logic cpu_owns_chan, // processor owns the channel
	input wire logic master_owns_chan, // another master owns the channel
	output logic master_grant_ok, // arbiter may grant another master
	output logic cpu_hold, // hold the processor's locked cycle
	input wire logic parity_err, // parity error pulse from memory
	output logic parity_check_en, // parity checking enabled
	output logic parity_pending, // parity error waiting to be cleared
	output logic cache_en, // internal and external caches enabled
	output logic timers_en, // bus request, hold and idle timers enabled
	output logic [7:0] split_base // split block start, A27-A20
);

	mcc_state_s s;
	mcc_state_s next_s;
	logic wr_idx;
	logic wr_data;
	logic rd_data;
	logic lock_on;
	logic [31:0] a;
	logic [31:0] low_end;
	logic [19:0] split_size;
	logic in_rom;
	logic in_lo4k;
	logic in_hirom;
	logic rom_claim;
	logic low_ram;
	logic nc_low;
	logic nc_win0;
	logic nc_win1;
	logic cpu_locked_now;

	always_comb begin
		next_s = s;
		wr_idx = io.wr && (io.addr == MCC_IDX_PORT);
		wr_data = io.wr && (io.addr == MCC_DATA_PORT);
		rd_data = io.rd && (io.addr == MCC_DATA_PORT);
		lock_on = !s.enc[ENC_LOCK_OFF];
		a = mem.addr;
		low_end = s.enc[ENC_LOW512] ? ADDR_LOW512_END : ADDR_LOW640_END; // see RQ6, see RQ7
		split_size = s.enc[ENC_LOW512] ? SPLIT_SIZE_384K : SPLIT_SIZE_256K; // see RQ6, see RQ7
		in_rom = (a >= ADDR_ROM_LO) && (a <= ADDR_ROM_HI);
		in_lo4k = (a >= ADDR_ROM_LO) && (a <= ADDR_ROM_LO4K_HI);
		in_hirom = (a >= ADDR_HIROM_LO);
		cpu_locked_now = lock_on && cpu_owns_chan && cpu_lock;

		// Register port access through index and data.
		if (wr_idx) begin // see RQ23
			next_s.idx = io.wdata;
		end
		if (wr_data) begin // see RQ23
			case (s.idx)
				MCC_IDX_SPLIT: next_s.split = io.wdata; // see RQ24
				MCC_IDX_ENC: next_s.enc = io.wdata & ENC_RW_MASK;
				MCC_IDX_CTL: next_s.ctl = io.wdata & CTL_RW_MASK;
				MCC_IDX_WIN0: next_s.win0 = io.wdata;
				default: next_s.idx = s.idx;
			endcase
		end
		if (io.rd && (io.addr == MCC_IDX_PORT)) begin
			next_s.rdata = s.idx;
		end else if (rd_data) begin
			case (s.idx)
				MCC_IDX_SPLIT: next_s.rdata = s.split;
				MCC_IDX_ENC: next_s.rdata = s.enc;
				MCC_IDX_CTL: next_s.rdata = s.ctl;
				MCC_IDX_WIN0: next_s.rdata = s.win0;
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Writing a one to the parity bit clears; a new error in the same cycle wins.
		if (wr_data && (s.idx == MCC_IDX_ENC) && io.wdata[ENC_PARITY_OFF]) begin // see RQ11
			next_s.parity_pend = 1'b0;
		end
		if (parity_err && !s.enc[ENC_PARITY_OFF]) begin // see RQ11
			next_s.parity_pend = 1'b1;
		end

		next_s.chan_ack = chan_req && !s.enc[ENC_ISOLATE]; // see RQ1

		// ROM space decode and read/write steering.
		rom_claim = (in_rom && (s.enc[ENC_ROM_DECODE] || !in_lo4k)) || // see RQ2
			(in_hirom && s.enc[ENC_ROM_DECODE]);
		low_ram = (a <= low_end); // see RQ6, see RQ7
		next_s.dec.valid = mem.valid;
		next_s.dec.rom = rom_claim && !mem.wr && s.enc[ENC_ROM_EN]; // see RQ9
		next_s.dec.wr_blocked = rom_claim && mem.wr && !s.enc[ENC_ROM_EN]; // see RQ9
		next_s.dec.split_hit = !s.enc[ENC_SPLIT_OFF] && (a[31:28] == 4'h0) && // see RQ5
			(a[27:20] == s.split) && (a[19:0] < split_size); // see RQ24
		next_s.dec.ram = low_ram || next_s.dec.split_hit ||
			(rom_claim && !next_s.dec.rom && !next_s.dec.wr_blocked);
		next_s.dec.no_mem = (a < ADDR_ROM_LO) && !low_ram; // see RQ7

		// Cacheability below 1MB and in both windows.
		nc_low = ((a > low_end) && (a < ADDR_ROM_LO)) || // see RQ8, see RQ19
			((a >= ADDR_HOLE_LO) && (a <= ADDR_HOLE_HI)) || // see RQ18
			(in_rom && s.enc[ENC_ROM_EN]); // see RQ18
		nc_win0 = !s.ctl[CTL_WIN0_OFF] && (a[31:24] == 8'h00) && // see RQ15, see RQ20, see RQ22
			(a[23:20] >= s.win0[WIN_LO_MSB:WIN_LO_LSB]) && // see RQ21
			(a[23:20] <= s.win0[WIN_HI_MSB:WIN_HI_LSB]); // see RQ21
		nc_win1 = !s.ctl[CTL_WIN1_OFF] && (a[31:28] == 4'h0) && // see RQ14
			(a[27:20] >= win1_lo) && (a[27:20] <= win1_hi); // see RQ21
		next_s.dec.cacheable = !s.ctl[CTL_CACHE_OFF] && !nc_low && !nc_win0 && !nc_win1;

		// Locked-cycle tracking.
		case (s.lock)
			MCC_LK_IDLE: begin
				if (cpu_locked_now) begin // see RQ3
					next_s.lock = MCC_LK_OWN;
				end else if (lock_on && cpu_lock && master_owns_chan) begin // see RQ4
					next_s.lock = MCC_LK_WAIT;
				end
			end
			MCC_LK_OWN: begin
				if (!cpu_lock) begin // see RQ3
					next_s.lock = MCC_LK_IDLE;
				end
			end
			MCC_LK_WAIT: begin
				if (!master_owns_chan) begin // see RQ4
					next_s.lock = MCC_LK_IDLE;
				end
			end
			default: next_s.lock = MCC_LK_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '{idx: IDX_RESET, split: SPLIT_RESET, enc: ENC_RESET, ctl: CTL_RESET,
				win0: WIN0_RESET, parity_pend: 1'b0, rdata: 8'h00, chan_ack: 1'b0,
				dec: '0, lock: MCC_LK_IDLE};
		end else if (ce) begin
			s <= next_s;
		end
	end

	// The grant block and the hold act in the same cycle as the lock so a master
	// cannot slip in during the one cycle the state register takes to follow.
	assign master_grant_ok = (s.lock != MCC_LK_OWN) && !cpu_locked_now; // see RQ3
	assign cpu_hold = (s.lock == MCC_LK_WAIT) ||
		(lock_on && cpu_lock && master_owns_chan && !cpu_owns_chan); // see RQ4
	assign io_hit = (io.rd || io.wr) && ((io.addr == MCC_IDX_PORT) || (io.addr == MCC_DATA_PORT));
	assign io_rdata = s.rdata;
	assign dec = s.dec;
	assign chan_ack = s.chan_ack;
	assign parity_check_en = !s.enc[ENC_PARITY_OFF]; // see RQ11
	assign parity_pending = s.parity_pend;
	assign cache_en = !s.ctl[CTL_CACHE_OFF]; // see RQ16
	assign timers_en = !s.ctl[CTL_TIMERS_OFF]; // see RQ13
	assign split_base = s.split;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	isolate_blocks_chan_a: assert property (ce && s.enc[ENC_ISOLATE] |=> !chan_ack) // see RQ1
		else $error("channel accepted while isolated");
	isolate_off_passes_a: assert property (ce && !s.enc[ENC_ISOLATE] && chan_req |=> chan_ack) // see RQ1
		else $error("channel refused while not isolated");
	lo4k_released_a: assert property (ce && !s.enc[ENC_ROM_DECODE] && (a >= ADDR_ROM_LO) && // see RQ2
		(a <= ADDR_ROM_LO4K_HI) |=> !dec.rom && !dec.ram && !dec.wr_blocked)
		else $error("low 4K of ROM space claimed with decode off");
	lock_blocks_grant_a: assert property (s.lock == MCC_LK_OWN |-> !master_grant_ok) // see RQ3
		else $error("master grant allowed during locked operation");
	locked_wait_a: assert property (ce && lock_on && cpu_lock && master_owns_chan && // see RQ4
		!cpu_owns_chan && s.lock == MCC_LK_IDLE |=> (s.lock == MCC_LK_WAIT) && cpu_hold)
		else $error("locked attempt not held");
	split_off_a: assert property (s.enc[ENC_SPLIT_OFF] |=> !dec.split_hit || $past(!ce)) // see RQ5
		else $error("split block hit while disabled");
	low512_gap_a: assert property (ce && s.enc[ENC_LOW512] && (a > ADDR_LOW512_END) && // see RQ7
		(a <= ADDR_LOW640_END) |=> dec.no_mem && !dec.cacheable)
		else $error("gap above 512KB decoded or cached");
	rom_steer_a: assert property (ce && s.enc[ENC_ROM_EN] && in_rom && !in_lo4k && // see RQ9
		!mem.wr |=> dec.rom && !dec.cacheable)
		else $error("ROM read not steered to ROM");
	rom_wr_block_a: assert property (ce && !s.enc[ENC_ROM_EN] && in_rom && !in_lo4k && // see RQ9
		mem.wr |=> dec.wr_blocked)
		else $error("write to ROM space not blocked");
	parity_set_a: assert property (ce && parity_err && !s.enc[ENC_PARITY_OFF] // see RQ11
		|=> parity_pending)
		else $error("parity error lost");
	parity_clear_a: assert property (ce && !parity_err && wr_data && s.idx == MCC_IDX_ENC && // see RQ11
		io.wdata[ENC_PARITY_OFF] |=> !parity_pending && !parity_check_en)
		else $error("parity error not cleared");
	cache_ctl_a: assert property (ce && wr_data && s.idx == MCC_IDX_CTL // see RQ16
		|=> cache_en == !$past(io.wdata[CTL_CACHE_OFF]))
		else $error("cache enable does not follow write");
	// An inverted window covers nothing, so the limit checks only apply to a real range.
	win0_hit_a: assert property (ce && !s.ctl[CTL_WIN0_OFF] && a[31:24] == 8'h00 && // see RQ21
		a[23:20] == s.win0[WIN_LO_MSB:WIN_LO_LSB] &&
		s.win0[WIN_LO_MSB:WIN_LO_LSB] <= s.win0[WIN_HI_MSB:WIN_HI_LSB] |=> !dec.cacheable)
		else $error("lower window limit not inclusive");
	hole_uncached_a: assert property (ce && (a >= ADDR_HOLE_LO) && (a <= ADDR_HOLE_HI) // see RQ18
		|=> !dec.cacheable)
		else $error("A0000-DFFFF cached");

	// Lock and grant checks.
	lock_own_a: assert property (lock_on && cpu_lock && cpu_owns_chan // see RQ3
		|-> !master_grant_ok)
		else $error("grant allowed as a locked cycle starts");
	lock_off_grant_a: assert property (s.enc[ENC_LOCK_OFF] && s.lock == MCC_LK_IDLE // see RQ3
		|-> master_grant_ok && !cpu_hold)
		else $error("lock disabled but grant or hold blocked");
	wait_holds_a: assert property (s.lock == MCC_LK_WAIT // see RQ4
		|-> cpu_hold)
		else $error("locked attempt released while master owns channel");

	// Address map checks.
	hirom_off_a: assert property (ce && !s.enc[ENC_ROM_DECODE] && in_hirom // see RQ2
		|=> !dec.rom && !dec.ram && !dec.wr_blocked)
		else $error("high ROM alias claimed with decode off");
	hirom_on_a: assert property (ce && s.enc[ENC_ROM_DECODE] && in_hirom && !mem.wr // see RQ2
		|=> dec.rom || dec.ram)
		else $error("high ROM alias read not claimed");
	low640_ram_a: assert property (ce && !s.enc[ENC_LOW512] && (a <= ADDR_LOW640_END) // see RQ6
		|=> dec.ram && !dec.no_mem)
		else $error("low 640KB not mapped to RAM");
	hole_no_mem_a: assert property (ce && (a >= ADDR_HOLE_LO) && (a <= ADDR_HOLE_HI) // see RQ6
		|=> dec.no_mem && !dec.ram)
		else $error("A0000-DFFFF decoded to memory");
	low512_ram_a: assert property (ce && s.enc[ENC_LOW512] && (a <= ADDR_LOW512_END) // see RQ7
		|=> dec.ram && !dec.no_mem)
		else $error("low 512KB not mapped to RAM");
	split640_size_a: assert property (ce && !s.enc[ENC_SPLIT_OFF] && !s.enc[ENC_LOW512] && // see RQ6
		(a[31:28] == 4'h0) && (a[27:20] == s.split) &&
		(a[19:0] >= SPLIT_SIZE_256K)
		|=> !dec.split_hit)
		else $error("split block larger than 256KB");
	split512_size_a: assert property (ce && !s.enc[ENC_SPLIT_OFF] && s.enc[ENC_LOW512] && // see RQ7
		(a[31:28] == 4'h0) && (a[27:20] == s.split) &&
		(a[19:0] < SPLIT_SIZE_384K)
		|=> dec.split_hit)
		else $error("split block smaller than 384KB");
	split_nc_a: assert property (ce && (a > low_end) && (a < ADDR_ROM_LO) // see RQ8, see RQ19
		|=> !dec.cacheable)
		else $error("space between split and 896KB cached");
	rom_off_read_a: assert property (ce && !s.enc[ENC_ROM_EN] && in_rom && !in_lo4k && // see RQ9
		!mem.wr |=> dec.ram && !dec.rom)
		else $error("read of ROM space not sent to RAM");
	rom_on_write_a: assert property (ce && s.enc[ENC_ROM_EN] && in_rom && !in_lo4k && // see RQ9
		mem.wr |=> dec.ram && !dec.wr_blocked)
		else $error("write of ROM space not sent to RAM");

	// Control bit checks.
	parity_en_a: assert property (ce && wr_data && (s.idx == MCC_IDX_ENC) // see RQ11
		|=> parity_check_en == !$past(io.wdata[ENC_PARITY_OFF]))
		else $error("parity check does not follow write");
	parity_off_a: assert property (ce && s.enc[ENC_PARITY_OFF] && !parity_pending // see RQ11
		|=> !parity_pending)
		else $error("parity error taken while check off");
	timers_ctl_a: assert property (ce && wr_data && (s.idx == MCC_IDX_CTL) // see RQ13
		|=> timers_en == !$past(io.wdata[CTL_TIMERS_OFF]))
		else $error("timer enable does not follow write");
	cache_off_a: assert property (ce && s.ctl[CTL_CACHE_OFF] // see RQ16
		|=> !dec.cacheable)
		else $error("address cached with cache off");

	// Cacheability checks with the windows.
	rom_cached_a: assert property (ce && !s.ctl[CTL_CACHE_OFF] && s.ctl[CTL_WIN0_OFF] && // see RQ18
		s.ctl[CTL_WIN1_OFF] && !s.enc[ENC_ROM_EN] && in_rom
		|=> dec.cacheable)
		else $error("ROM space uncached with ROM off");
	win_off_a: assert property (ce && !s.ctl[CTL_CACHE_OFF] && s.ctl[CTL_WIN0_OFF] && // see RQ20
		s.ctl[CTL_WIN1_OFF] && (a[31:24] == 8'h00) && (a[23:20] != 4'h0)
		|=> dec.cacheable)
		else $error("1MB-16MB uncached with checks off");
	win0_above_a: assert property (ce && !s.ctl[CTL_CACHE_OFF] && s.ctl[CTL_WIN1_OFF] && // see RQ21
		(a[31:24] == 8'h00) && (a[23:20] > s.win0[WIN_HI_MSB:WIN_HI_LSB])
		|=> dec.cacheable)
		else $error("address above lower window uncached");
	win0_a24_a: assert property (ce && !s.ctl[CTL_CACHE_OFF] && s.ctl[CTL_WIN1_OFF] && // see RQ22
		(a[31:24] != 8'h00)
		|=> dec.cacheable)
		else $error("lower window matched with high address bits set");
	win1_hit_a: assert property (ce && !s.ctl[CTL_WIN1_OFF] && (a[31:28] == 4'h0) && // see RQ14
		(a[27:20] == win1_hi) && (win1_lo <= win1_hi)
		|=> !dec.cacheable)
		else $error("upper window limit not inclusive");

	// Register port checks.
	idx_read_a: assert property (ce && io.rd && (io.addr == MCC_IDX_PORT) // see RQ23
		|=> io_rdata == $past(s.idx))
		else $error("index read back wrong");
	enc_read_a: assert property (ce && rd_data && (s.idx == MCC_IDX_ENC) // see RQ23
		|=> io_rdata == $past(s.enc))
		else $error("encoding register read back wrong");
	split_wr_a: assert property (ce && wr_data && (s.idx == MCC_IDX_SPLIT) // see RQ24
		|=> split_base == $past(io.wdata))
		else $error("split register does not follow write");

	locked_wait_c: cover property (s.lock == MCC_LK_WAIT ##1 s.lock == MCC_LK_IDLE);
	parity_cycle_c: cover property (parity_pending ##[1:20] !parity_pending);
	split_hit_c: cover property (dec.split_hit && dec.cacheable);
	win0_nc_c: cover property (dec.valid && !dec.cacheable && cache_en && a[23:20] != 4'h0);
	win1_nc_c: cover property (nc_win1 && cache_en ##1 !dec.cacheable);

endmodule // mcc_regs

/* test/mcc_cpu_model.sv */
// Processor model that runs index and data port cycles into the register block.
// Assumes the block samples strobes on the rising edge of ref_clk.
`timescale 1ns/1ps
module mcc_cpu_model
	import mcc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic [7:0] io_rdata, // read data from the block
	output mcc_io_s io // I/O request to the block
);
	initial io = '0;
	// Each access is a one-cycle strobe; the bus is cleared after it.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk) io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge ref_clk) io <= '0;
	endtask
	// Read data is taken once the strobe edge has landed.
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge ref_clk) io <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge ref_clk) io <= '0;
		d = io_rdata;
	endtask
endmodule // mcc_cpu_model

/* test/mcc_tb.sv */
// Self-checking bench for the memory-map and cache control registers.
// Assumes the processor model drives the port bus; other inputs change at falling edges.
`timescale 1ns/1ps
module testbench
	import mcc_pkg::*;
;
	logic ref_clk = 0, rstn = 0, chan_req = 0, cpu_lock = 0, cpu_own = 0, mst_own = 0;
	logic perr = 0, io_hit, chan_ack, grant_ok, cpu_hold, pchk, ppend, cache_en, timers_en;
	logic ce = 1;
	logic [7:0] win1_lo = 8'h00, win1_hi = 8'h00;
	logic [7:0] rdata, split_base;
	mcc_io_s io;
	mcc_mem_s mem = '0;
	mcc_dec_s dec;
	int errors = 0, check_count = 0;
	initial forever #2.5 ref_clk = ~ref_clk;
	mcc_cpu_model cpu (.ref_clk(ref_clk), .io_rdata(rdata), .io(io));
	mcc_regs dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .io(io), .io_hit(io_hit),
		.io_rdata(rdata), .mem(mem), .dec(dec), .win1_lo(win1_lo), .win1_hi(win1_hi),
		.chan_req(chan_req), .chan_ack(chan_ack), .cpu_lock(cpu_lock),
		.cpu_owns_chan(cpu_own), .master_owns_chan(mst_own), .master_grant_ok(grant_ok),
		.cpu_hold(cpu_hold), .parity_err(perr), .parity_check_en(pchk),
		.parity_pending(ppend), .cache_en(cache_en), .timers_en(timers_en),
		.split_base(split_base));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic rw(input logic [7:0] i, input logic [7:0] d);
		cpu.wr(MCC_IDX_PORT, i);
		cpu.wr(MCC_DATA_PORT, d);
	endtask
	task automatic rr(input logic [7:0] i, input logic [7:0] e);
		logic [7:0] d;
		cpu.wr(MCC_IDX_PORT, i);
		cpu.rd(MCC_DATA_PORT, d);
		chk(d, e, "readback");
	endtask
	task automatic hit(input logic [15:0] a, input logic e);
		fork
			cpu.wr(a, 8'h00);
			begin
				@(negedge ref_clk);
				#1 chk(io_hit, e, "io hit");
			end
		join
	endtask
	task automatic cls(input logic [31:0] a, input logic w);
		@(negedge ref_clk) mem <= '{valid: 1'b1, wr: w, addr: a};
		@(negedge ref_clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_regs();
		rr(MCC_IDX_ENC, ENC_RESET);
		rr(MCC_IDX_CTL, CTL_RESET);
		rr(MCC_IDX_WIN0, WIN0_RESET);
		rr(8'h55, 8'h00);
		hit(MCC_IDX_PORT, 1'b1);
		hit(16'h00e2, 1'b0);
		// With the clock enable low the write below must leave the register alone.
		@(negedge ref_clk) ce <= 0;
		rw(MCC_IDX_CTL, 8'h01);
		@(negedge ref_clk) ce <= 1;
		rr(MCC_IDX_CTL, CTL_RESET);
		rw(MCC_IDX_ENC, 8'hff);
		rr(MCC_IDX_ENC, ENC_RW_MASK);
		rw(MCC_IDX_CTL, 8'hff);
		rr(MCC_IDX_CTL, CTL_RW_MASK);
		chk({cache_en, timers_en}, 2'b00, "cache timers off");
		// Software flushes the caches around this change; this block holds no lines.
		rw(MCC_IDX_CTL, 8'h00);
		chk({cache_en, timers_en}, 2'b11, "cache timers on");
		$display("test regs done");
	endtask
	task automatic t_chan();
		rw(MCC_IDX_ENC, ENC_RESET);
		@(negedge ref_clk) chan_req <= 1;
		@(negedge ref_clk) chk(chan_ack, 0, "isolated");
		rw(MCC_IDX_ENC, 8'h2b);
		@(negedge ref_clk) chk(chan_ack, 1, "channel on");
		chan_req <= 0;
		@(negedge ref_clk) {cpu_lock, cpu_own} <= 2'b11;
		#1 chk(grant_ok, 0, "locked own");
		@(negedge ref_clk) cpu_own <= 0;
		#1 chk(grant_ok, 0, "lock persists");
		@(negedge ref_clk) cpu_lock <= 0;
		@(negedge ref_clk) chk(grant_ok, 1, "lock done");
		{cpu_lock, mst_own} <= 2'b11;
		#1 chk(cpu_hold, 1, "hold cpu");
		@(negedge ref_clk) mst_own <= 0;
		@(negedge ref_clk) chk(cpu_hold, 0, "master gone");
		cpu_lock <= 0;
		$display("test channel done");
	endtask
	task automatic t_map();
		rw(MCC_IDX_CTL, 8'h86);
		rw(MCC_IDX_ENC, ENC_RESET);
		cls(ADDR_ROM_LO, 0);
		chk({dec.rom, dec.cacheable}, 2'b10, "rom read");
		cls(ADDR_ROM_LO, 1);
		chk(dec.ram, 1, "rom write ram");
		cls(ADDR_HOLE_LO, 0);
		chk({dec.valid, dec.no_mem, dec.cacheable}, 3'b110, "hole");
		cls(32'h00050000, 0);
		chk(dec.cacheable, 1, "low cached");
		// ROM off is the preferred setting, together with the 512KB split.
		rw(MCC_IDX_ENC, 8'had);
		cls(ADDR_ROM_LO, 1);
		chk(dec.wr_blocked, 1, "rom off write");
		cls(ADDR_ROM_LO, 0);
		chk({dec.ram, dec.rom, dec.cacheable}, 3'b101, "rom off read");
		cls(32'h00080000, 0);
		chk({dec.no_mem, dec.cacheable}, 2'b10, "gap");
		cls(ADDR_LOW512_END, 0);
		chk({dec.ram, dec.cacheable}, 2'b11, "low512 end");
		rw(MCC_IDX_ENC, 8'h8d);
		cls(ADDR_ROM_LO, 0);
		chk({dec.ram, dec.rom}, 2'b00, "decode off");
		rw(MCC_IDX_SPLIT, 8'h05);
		rw(MCC_IDX_ENC, 8'ha3);
		chk(split_base, 8'h05, "split base");
		cls(32'h0053ffff, 0);
		chk(dec.split_hit, 1, "split end");
		cls(32'h00540000, 0);
		chk(dec.split_hit, 0, "past split");
		$display("test map done");
	endtask
	task automatic t_win();
		rw(MCC_IDX_CTL, 8'h84);
		rw(MCC_IDX_WIN0, 8'h32);
		cls(32'h00200000, 0);
		chk(dec.cacheable, 0, "win low end");
		cls(32'h003fffff, 0);
		chk(dec.cacheable, 0, "win high end");
		cls(32'h00400000, 0);
		chk(dec.cacheable, 1, "above win");
		cls(32'h001fffff, 0);
		chk(dec.cacheable, 1, "below win");
		cls(32'h01200000, 0);
		chk(dec.cacheable, 1, "a24 set");
		rw(MCC_IDX_CTL, 8'h86);
		cls(32'h00200000, 0);
		chk(dec.cacheable, 1, "check off");
		win1_lo <= 8'h12;
		win1_hi <= 8'h12;
		rw(MCC_IDX_CTL, 8'h80);
		cls(32'h01200000, 0);
		chk(dec.cacheable, 0, "upper window");
		cls(32'h01300000, 0);
		chk(dec.cacheable, 1, "above upper");
		$display("test window done");
	endtask
	task automatic t_par();
		rw(MCC_IDX_ENC, 8'ha2);
		chk(pchk, 1, "parity on");
		@(negedge ref_clk) perr <= 1;
		@(negedge ref_clk) perr <= 0;
		chk(ppend, 1, "pending");
		// Software clears here first and then at the system control port.
		rw(MCC_IDX_ENC, 8'ha3);
		@(negedge ref_clk) chk(ppend, 0, "cleared");
		$display("test parity done");
	endtask
	initial begin
		repeat (4) @(negedge ref_clk);
		rstn = 1;
		t_regs();
		t_chan();
		t_map();
		t_win();
		t_par();
		close_out();
	end
	// The whole sequence needs about 160 cycles.
	initial begin
		#20000;
		errors++;
		close_out();
	end
endmodule // testbench
